// file: src/plpc_pkg.sv
// Constants, encodings and helpers for the port link power control block.
// Assumes a single 20 MHz core clock shared by all users of the package.
package plpc_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int UPDATE_PERIOD_MS = 40;
    localparam int ACT_HOLD_MS = 200;
    localparam int UPDATE_CYCLES = CLK_HZ / 1000 * UPDATE_PERIOD_MS;
    localparam int ACT_HOLD_UPDATES = (ACT_HOLD_MS + UPDATE_PERIOD_MS - 1) / UPDATE_PERIOD_MS;

    // ---------------------------------------------------------------
    // Register offsets and fields
    // ---------------------------------------------------------------
    localparam logic [7:0] REG_DEVCAP = 8'h00;
    localparam logic [7:0] REG_LCTL = 8'h04;
    localparam logic [7:0] REG_LCTL2 = 8'h08;
    localparam logic [7:0] REG_SERDES = 8'h0C;
    localparam logic [7:0] REG_LSTS2 = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_SCAP_BASE = 8'h20;
    localparam int ASPM_L0S_BIT = 0;
    localparam int ASPM_L1_BIT = 1;
    localparam int D3HOT_BIT = 8;
    localparam int SCALE_LSB = 0;
    localparam int VALUE_LSB = 8;
    localparam int VALID_LSB = 8;
    localparam int L1ST_LSB = 8;
    localparam int L23_LSB = 16;
    localparam logic [31:0] LCTL_RST = 32'h0000_0000;
    localparam logic [31:0] LCTL2_RST = 32'h0000_0000;
    localparam logic [31:0] SERDES_RST = 32'h0000_0000;
    localparam logic [9:0] SCAP_RST = 10'h000;

    // ---------------------------------------------------------------
    // Encodings
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        LT_DETECT = 4'h0, LT_POLLING = 4'h1, LT_CONFIG = 4'h2, LT_DISABLED = 4'h3,
        LT_LOOPBACK = 4'h4, LT_HOTRESET = 4'h5, LT_L0 = 4'h6, LT_L0S = 4'h7,
        LT_L1 = 4'h8, LT_RECOVERY = 4'h9, LT_L2L3 = 4'hA
    } plpc_ltssm_t;

    typedef enum logic [1:0] {
        L1S_L0 = 2'h0, L1S_REQ = 2'h1, L1S_L1 = 2'h2
    } plpc_l1st_t;

    function automatic logic plpc_is_up(input logic [3:0] s);
        plpc_is_up = (s == LT_L0) || (s == LT_L0S) || (s == LT_L1) || (s == LT_RECOVERY);
    endfunction : plpc_is_up

endpackage : plpc_pkg

// file: src/plpc_update_timer.sv
// Update tick generator for the expander-carried status outputs.
// Assumes one free-running core clock.
`timescale 1ns/1ns
module plpc_update_timer
    import plpc_pkg::*;
#(
    parameter int PERIOD = UPDATE_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    output logic tick
);
    localparam int CW = $clog2(PERIOD);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic wrap;

    assign wrap = (cnt_r == CW'(PERIOD - 1));
    assign cnt_nxt = wrap ? '0 : cnt_r + CW'(1);
    assign tick = wrap;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt; // see [RULE_16]
        end
    end

    a_tick_spacing: assert property (@(posedge clk) disable iff (!rstn)
        tick |=> !tick) // see [RULE_16]
        else $error("update ticks too close");

endmodule : plpc_update_timer

// file: src/plpc_activity_hold.sv
// Per-port activity stretcher counted in status update periods.
// Assumes tick comes from the update timer on the same clock.
`timescale 1ns/1ns
module plpc_activity_hold
    import plpc_pkg::*;
#(
    parameter int N = 3,
    parameter int HOLD = ACT_HOLD_UPDATES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tick,
    input wire logic [N-1:0] act_evt,
    output logic [N-1:0] held
);
    logic [N-1:0] pend_r;
    logic [N-1:0] pend_nxt;
    logic [N-1:0][3:0] cnt_r;
    logic [N-1:0][3:0] cnt_nxt;

    // Event in the tick cycle still loads, so nothing is lost
    assign pend_nxt = act_evt | (pend_r & {N{~tick}});

    always_comb begin
        for (int i = 0; i < N; i++) begin
            cnt_nxt[i] = cnt_r[i];
            if (tick && (pend_r[i] || act_evt[i])) begin
                cnt_nxt[i] = 4'(HOLD); // see [RULE_15]
            end else if (tick && cnt_r[i] != 4'h0) begin
                cnt_nxt[i] = cnt_r[i] - 4'h1;
            end
            held[i] = (cnt_r[i] != 4'h0);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend_r <= '0;
            cnt_r <= '0;
        end else begin
            pend_r <= pend_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    a_hold_load: assert property (@(posedge clk) disable iff (!rstn)
        (tick && pend_r[0]) |=> (cnt_r[0] == 4'(HOLD))) // see [RULE_15]
        else $error("activity hold not loaded");

endmodule : plpc_activity_hold

// file: src/plpc_port_link_power_control.sv
// Port link power control: slot power limit, ASPM, indicators, de-emphasis.
// Port 0 is the upstream port, ports 1..NP-1 are downstream.
// Assumes LTSSM, traffic and message inputs come from logic on clk.
//
// Behaviour
// [RULE_01] Upstream captures slot power scale and value
// [RULE_02] Slot capability write while up sends message
// [RULE_03] Downstream link coming up sends message
// [RULE_04] L2/L3 Ready after turn-off ack, traffic stops
// [RULE_05] L1 allowed by ASPM or D3hot
// [RULE_06] Training states form one link-down state
// [RULE_07] ASPM enables hardware L0s and L1 entry
// [RULE_08] Upstream L0s needs active downstream receivers idle
// [RULE_09] Downstream L0s needs upstream receiver in L0s
// [RULE_10] L0s needs no sendable TLP, no DLLP
// [RULE_11] Upstream alone requests L1; nak falls to L0s
// [RULE_12] L1 request only when active downstreams in L1
// [RULE_13] Link-up indicator follows data link layer state
// [RULE_14] Non-vendor TLP traffic marks activity
// [RULE_15] Activity indicator held at least 200 ms
// [RULE_16] Indicators change at most every 40 ms
// [RULE_17] 3.5 dB at Gen1, selectable at Gen2
// [RULE_18] One de-emphasis level, settled in Recovery
// [RULE_19] Upstream advertises select, adopts partner decision
// [RULE_20] Downstream imposes its own select field
// [RULE_21] Low swing disables de-emphasis, status invalid
// [RULE_22] Indicators are active-low outputs
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module plpc_port_link_power_control
    import plpc_pkg::*;
#(
    parameter int NP = 3,
    parameter int PERIOD = UPDATE_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [NP-1:0][3:0] ltssm,
    input wire logic [NP-1:0] rate_5g,
    input wire logic [NP-1:0] rx_l0s,
    input wire logic [NP-1:0] tlp_pending,
    input wire logic [NP-1:0] fc_credit_ok,
    input wire logic [NP-1:0] dllp_pending,
    input wire logic [NP-1:0] port_in_d3,
    input wire logic [NP-1:0] pm_turn_off_acked,
    input wire logic l1_ack,
    input wire logic l1_nak,
    input wire logic spl_rx_valid,
    input wire logic [7:0] spl_rx_byte0,
    input wire logic [7:0] spl_rx_byte1,
    input wire logic [NP-1:0] tlp_seen,
    input wire logic [NP-1:0] tlp_vendor_msg,
    input wire logic partner_deemph_6db,
    output logic [NP-1:0] tx_l0s_enter,
    output logic l1_req,
    output logic l1_active,
    output logic [NP-1:0] l23_ready,
    output logic [NP-1:0] spl_send,
    output logic [NP-1:0][9:0] spl_payload,
    output logic adv_deemph_6db,
    output logic [NP-1:0] tx_deemph_6db,
    output logic [NP-1:0] tx_deemph_en,
    output logic [NP-1:0] tx_low_swing,
    output logic [NP-1:0] port_link_up_ind_n,
    output logic [NP-1:0] port_activity_ind_n
);

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [31:0] link_control_reg_r;
    logic [31:0] link_control2_reg_r;
    logic [31:0] serdes_control_reg_r;
    logic [9:0] device_capabilities_reg_r;
    logic [NP-1:0][9:0] slot_capabilities_reg_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [NP-1:0] up_d_r;
    logic [NP-1:0] l23_r;
    logic [NP-1:0] l23_nxt;
    logic [NP-1:0] deemph_cur_r;
    logic [NP-1:0] deemph_cur_nxt;
    logic [NP-1:0] spl_send_r;
    logic [NP-1:0] spl_send_nxt;
    logic [NP-1:0][9:0] spl_payload_r;
    logic [NP-1:0] link_ind_n_r;
    logic [NP-1:0] act_ind_n_r;
    plpc_l1st_t l1st_r;
    plpc_l1st_t l1st_nxt;
    logic fallback_r;
    logic fallback_nxt;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    logic [NP-1:0] link_up;
    logic [NP-1:0] in_l1;
    logic [NP-1:0] scap_hit;
    logic [NP-1:0] idle_tx;
    logic [NP-1:0] ds_active;
    logic [NP-1:0] act_evt;
    logic [NP-1:0] act_held;
    logic [NP-1:0] deemph_select;
    logic [NP-1:0] low_swing_enable;
    logic [7:0] captured_power_scale;
    logic [1:0] captured_power_value;
    logic aspm_l0s_en;
    logic aspm_l1_en;
    logic d3hot;
    logic us_rx_ok;
    logic all_ds_l1;
    logic l1_allowed;
    logic us_in_l0;
    logic tick;

    assign aspm_l0s_en = link_control_reg_r[ASPM_L0S_BIT];
    assign aspm_l1_en = link_control_reg_r[ASPM_L1_BIT];
    assign d3hot = link_control_reg_r[D3HOT_BIT];
    assign deemph_select = link_control2_reg_r[NP-1:0];
    assign low_swing_enable = serdes_control_reg_r[NP-1:0];
    assign captured_power_scale = device_capabilities_reg_r[SCALE_LSB +: 8];
    assign captured_power_value = device_capabilities_reg_r[VALUE_LSB +: 2];

    always_comb begin
        us_rx_ok = 1'b1;
        all_ds_l1 = 1'b1;
        for (int i = 0; i < NP; i++) begin
            link_up[i] = plpc_is_up(ltssm[i]); // see [RULE_06]
            in_l1[i] = (ltssm[i] == LT_L1);
            scap_hit[i] = (i != 0) && reg_wr && (reg_addr == REG_SCAP_BASE + 8'(4 * i));
            idle_tx[i] = (!tlp_pending[i] || !fc_credit_ok[i]) && !dllp_pending[i]; // see [RULE_10]
            ds_active[i] = (i != 0) && !port_in_d3[i] && link_up[i];
            act_evt[i] = tlp_seen[i] && !tlp_vendor_msg[i]; // see [RULE_14]
            if (ds_active[i] && !rx_l0s[i]) begin
                us_rx_ok = 1'b0; // see [RULE_08]
            end
            if (ds_active[i] && !in_l1[i]) begin
                all_ds_l1 = 1'b0; // see [RULE_12]
            end
        end
    end

    // ---------------------------------------------------------------
    // L0s entry
    // ---------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            if (i == 0) begin
                tx_l0s_enter[i] = link_up[i] && !l23_r[i] && idle_tx[i] && us_rx_ok
                    && (aspm_l0s_en || fallback_r); // see [RULE_07] see [RULE_08]
            end else begin
                tx_l0s_enter[i] = link_up[i] && !l23_r[i] && idle_tx[i] && rx_l0s[0]
                    && aspm_l0s_en; // see [RULE_09]
            end
        end
    end

    // ---------------------------------------------------------------
    // Upstream L1 request
    // ---------------------------------------------------------------
    assign us_in_l0 = (ltssm[0] == LT_L0) || (ltssm[0] == LT_L0S);
    assign l1_allowed = (aspm_l1_en || d3hot) && us_in_l0 && idle_tx[0]
        && all_ds_l1 && !l23_r[0]; // see [RULE_05] see [RULE_12]

    always_comb begin
        l1st_nxt = l1st_r;
        fallback_nxt = fallback_r && us_in_l0 && idle_tx[0];
        unique case (l1st_r)
            L1S_L0: begin
                if (l1_allowed && !fallback_r) begin
                    l1st_nxt = L1S_REQ; // see [RULE_11]
                end
            end
            L1S_REQ: begin
                if (l1_ack) begin
                    l1st_nxt = L1S_L1;
                end else if (l1_nak || !link_up[0]) begin
                    l1st_nxt = L1S_L0;
                    fallback_nxt = link_up[0]; // see [RULE_11]
                end
            end
            L1S_L1: begin
                if (!idle_tx[0] || !in_l1[0] && !l1_ack) begin
                    l1st_nxt = L1S_L0;
                end
            end
            default: begin
                l1st_nxt = L1S_L0;
            end
        endcase
    end

    assign l1_req = (l1st_r == L1S_REQ);
    assign l1_active = (l1st_r == L1S_L1);

    // ---------------------------------------------------------------
    // L2/L3 Ready, slot power, de-emphasis
    // ---------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            // Held until the link really drops, then training restarts
            l23_nxt[i] = pm_turn_off_acked[i] || (l23_r[i] && link_up[i]); // see [RULE_04]
            spl_send_nxt[i] = (i != 0) && ((scap_hit[i] && link_up[i])
                || (link_up[i] && !up_d_r[i])); // see [RULE_02] see [RULE_03]
            deemph_cur_nxt[i] = deemph_cur_r[i];
            if (ltssm[i] == LT_RECOVERY) begin
                deemph_cur_nxt[i] = (i == 0) ? partner_deemph_6db
                    : deemph_select[i]; // see [RULE_18] see [RULE_19] see [RULE_20]
            end
        end
    end

    assign l23_ready = l23_r;
    assign spl_send = spl_send_r;
    assign spl_payload = spl_payload_r;
    assign adv_deemph_6db = deemph_select[0]; // see [RULE_19]
    assign tx_low_swing = low_swing_enable; // see [RULE_21]
    assign tx_deemph_en = ~low_swing_enable; // see [RULE_21]
    assign tx_deemph_6db = deemph_cur_r & rate_5g & ~low_swing_enable; // see [RULE_17]

    // ---------------------------------------------------------------
    // Register read mux
    // ---------------------------------------------------------------
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_addr == REG_DEVCAP) begin
            rdata_nxt[9:0] = device_capabilities_reg_r;
        end else if (reg_addr == REG_LCTL) begin
            rdata_nxt = link_control_reg_r;
        end else if (reg_addr == REG_LCTL2) begin
            rdata_nxt = link_control2_reg_r;
        end else if (reg_addr == REG_SERDES) begin
            rdata_nxt = serdes_control_reg_r;
        end else if (reg_addr == REG_LSTS2) begin
            rdata_nxt[NP-1:0] = deemph_cur_r;
            rdata_nxt[VALID_LSB +: NP] = ~low_swing_enable; // see [RULE_21]
        end else if (reg_addr == REG_STATUS) begin
            rdata_nxt[NP-1:0] = link_up;
            rdata_nxt[L1ST_LSB +: 2] = l1st_r;
            rdata_nxt[L23_LSB +: NP] = l23_r;
        end
        for (int i = 1; i < NP; i++) begin
            if (reg_addr == REG_SCAP_BASE + 8'(4 * i)) begin
                rdata_nxt[9:0] = slot_capabilities_reg_r[i];
            end
        end
    end

    assign reg_rdata = rdata_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link_control_reg_r <= LCTL_RST;
            link_control2_reg_r <= LCTL2_RST;
            serdes_control_reg_r <= SERDES_RST;
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= reg_rd ? rdata_nxt : 32'h0000_0000;
            if (reg_wr && reg_addr == REG_LCTL) begin
                link_control_reg_r <= reg_wdata;
            end
            if (reg_wr && reg_addr == REG_LCTL2) begin
                link_control2_reg_r <= reg_wdata;
            end
            if (reg_wr && reg_addr == REG_SERDES) begin
                serdes_control_reg_r <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            device_capabilities_reg_r <= 10'h000;
            slot_capabilities_reg_r <= {NP{SCAP_RST}};
            spl_payload_r <= {NP{SCAP_RST}};
        end else begin
            if (spl_rx_valid) begin
                device_capabilities_reg_r <= {spl_rx_byte1[1:0], spl_rx_byte0}; // see [RULE_01]
            end
            for (int i = 1; i < NP; i++) begin
                if (scap_hit[i]) begin
                    slot_capabilities_reg_r[i] <= reg_wdata[9:0];
                end
                if (spl_send_nxt[i]) begin
                    spl_payload_r[i] <= scap_hit[i] ? reg_wdata[9:0]
                        : slot_capabilities_reg_r[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            up_d_r <= '0;
            l23_r <= '0;
            deemph_cur_r <= '0;
            spl_send_r <= '0;
            l1st_r <= L1S_L0;
            fallback_r <= 1'b0;
        end else begin
            up_d_r <= link_up;
            l23_r <= l23_nxt;
            deemph_cur_r <= deemph_cur_nxt;
            spl_send_r <= spl_send_nxt;
            l1st_r <= l1st_nxt;
            fallback_r <= fallback_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Indicators
    // ---------------------------------------------------------------
    plpc_update_timer #(.PERIOD(PERIOD)) u_timer (
        .clk(clk),
        .rstn(rstn),
        .tick(tick)
    );

    plpc_activity_hold #(.N(NP), .HOLD(ACT_HOLD_UPDATES)) u_hold (
        .clk(clk),
        .rstn(rstn),
        .tick(tick),
        .act_evt(act_evt),
        .held(act_held)
    );

    // Slow expander only refreshes on the tick; short link blips are not shown
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link_ind_n_r <= '1;
            act_ind_n_r <= '1;
        end else if (tick) begin
            link_ind_n_r <= ~link_up; // see [RULE_13] see [RULE_16] see [RULE_22]
            act_ind_n_r <= ~act_held; // see [RULE_15] see [RULE_22]
        end
    end

    assign port_link_up_ind_n = link_ind_n_r;
    assign port_activity_ind_n = act_ind_n_r;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_devcap_capture: assert property (spl_rx_valid |=> // see [RULE_01]
        captured_power_scale == $past(spl_rx_byte0)
        && captured_power_value == $past(spl_rx_byte1[1:0]))
        else $error("power limit not captured");
    a_spl_on_write: assert property ((scap_hit[1] && link_up[1]) |=> spl_send[1]) // see [RULE_02]
        else $error("no power message after write");
    a_spl_on_linkup: assert property ($rose(link_up[1]) |=> spl_send[1]) // see [RULE_03]
        else $error("no power message at link up");
    a_l23_cause: assert property ($rose(l23_ready[0]) |-> $past(pm_turn_off_acked[0])) // see [RULE_04]
        else $error("L2/L3 Ready without ack");
    a_l1_req_cond: assert property ($rose(l1_req) |-> $past(all_ds_l1 && us_in_l0)) // see [RULE_12]
        else $error("L1 requested too early");
    a_l1_fallback: assert property ((l1_req && l1_nak && !l1_ack && link_up[0]) |=> // see [RULE_11]
        (fallback_r && !l1_req))
        else $error("no L0s fallback after nak");
    a_us_l0s_gate: assert property (tx_l0s_enter[0] |-> (us_rx_ok && idle_tx[0])) // see [RULE_08]
        else $error("upstream L0s gate broken");
    a_ds_l0s_gate: assert property (tx_l0s_enter[1] |-> (rx_l0s[0] && idle_tx[1])) // see [RULE_09]
        else $error("downstream L0s gate broken");
    a_ind_stable: assert property (!tick |=> $stable(port_link_up_ind_n)) // see [RULE_16]
        else $error("indicator changed off tick");
    a_linkup_ind: assert property ((tick && link_up[0]) |=> !port_link_up_ind_n[0]) // see [RULE_13]
        else $error("link-up indicator not asserted");
    a_ds_deemph: assert property ((ltssm[1] == LT_RECOVERY) |=> // see [RULE_20]
        deemph_cur_r[1] == $past(deemph_select[1]))
        else $error("downstream de-emphasis not imposed");
    a_low_swing: assert property (low_swing_enable[0] |-> // see [RULE_21]
        (!tx_deemph_en[0] && !tx_deemph_6db[0]))
        else $error("de-emphasis active in low swing");
    c_l1_entry: cover property (l1_req ##1 l1_active);
    c_l1_nak: cover property (l1_req && l1_nak);
    c_spl_send: cover property (spl_send[1]);
    c_activity: cover property ($fell(port_activity_ind_n[0]));

endmodule : plpc_port_link_power_control

// file: verification/plpc_link_partner.sv
// Link partner model: answers L1 requests, decides upstream de-emphasis.
// Assumes the bench feeds in_l1 back into the upstream LTSSM code.
`timescale 1ns/1ns
module plpc_link_partner #(
    parameter logic DEEMPH_6DB = 1'b0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic l1_req,
    input wire logic [3:0] lat,
    output logic l1_ack,
    output logic in_l1,
    output logic deemph_6db
);
    logic [3:0] cnt_r;

    assign deemph_6db = DEEMPH_6DB;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 4'h0;
            l1_ack <= 1'b0;
            in_l1 <= 1'b0;
        end else begin
            // Delay set by lat, so slow partners can be modelled
            cnt_r <= (l1_req && !l1_ack) ? cnt_r + 4'h1 : 4'h0;
            l1_ack <= l1_req && !l1_ack && (cnt_r == lat);
            in_l1 <= in_l1 | l1_ack;
        end
    end
endmodule : plpc_link_partner

// file: verification/plpc_port_link_power_control_tb.sv
// Self-checking bench for the port link power control block, three ports.
// Assumes the design sources and the partner model are compiled first.
`timescale 1ns/1ns
module plpc_port_link_power_control_tb;
    import plpc_pkg::*;
    logic clk, rstn, reg_wr, reg_rd, l1_ack, l1_nak, spl_rx_valid, in_l1, pd6;
    logic l1_req, l1_active, adv_deemph_6db;
    logic rd_d = 1'b0;
    logic [7:0] reg_addr, spl_rx_byte0, spl_rx_byte1;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [31:0] seed = 32'h0000FFCA;
    logic [2:0][3:0] lt;
    logic [2:0] rate_5g, rx_l0s, tlp_pending, fc_credit_ok, dllp_pending, port_in_d3;
    logic [2:0] pm_turn_off_acked, tlp_seen, tlp_vendor_msg, tx_l0s_enter, l23_ready;
    logic [2:0] spl_send, tx_deemph_6db, tx_deemph_en, tx_low_swing;
    logic [2:0] port_link_up_ind_n, port_activity_ind_n;
    logic [2:0][9:0] spl_payload;
    // Fields rx_l0s, tlp_pending, fc_credit_ok, dllp_pending, 3 bits each
    logic [11:0] pat[5] = '{12'h290, 12'h280, 12'h204, 12'hE00, 12'hC00};
    logic [2:0] exl[5] = '{3'h4, 3'h6, 3'h2, 3'h7, 3'h1};
    logic [31:0] rq[$];
    logic [12:0] sq[$];
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    wire logic [2:0][3:0] ltssm = {lt[2], lt[1], in_l1 ? LT_L1 : lt[0]};

    plpc_port_link_power_control #(.NP(3), .PERIOD(20)) i_dut (.clk, .rstn, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ltssm, .rate_5g, .rx_l0s, .tlp_pending,
        .fc_credit_ok, .dllp_pending, .port_in_d3, .pm_turn_off_acked, .l1_ack, .l1_nak,
        .spl_rx_valid, .spl_rx_byte0, .spl_rx_byte1, .tlp_seen, .tlp_vendor_msg,
        .partner_deemph_6db(pd6), .tx_l0s_enter, .l1_req, .l1_active, .l23_ready, .spl_send,
        .spl_payload, .adv_deemph_6db, .tx_deemph_6db, .tx_deemph_en, .tx_low_swing,
        .port_link_up_ind_n, .port_activity_ind_n);

    plpc_link_partner i_partner (.clk, .rstn, .l1_req, .lat(4'h2), .l1_ack, .in_l1,
        .deemph_6db(pd6));

    // ---------------------------------------------------------------
    // Bus tasks, compares, monitor
    // ---------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_rd

    task automatic chk_pin(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_pin

    task automatic wrap_up();
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d)
            chk_rd(rq.pop_front(), reg_rdata);
        if (|spl_send)
            chk_pin({spl_send, spl_payload[spl_send[2] ? 2 : 1]}, sq.pop_front());
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        {rstn, reg_wr, reg_rd, spl_rx_valid, l1_nak, reg_addr, reg_wdata} = '0;
        {spl_rx_byte0, spl_rx_byte1, tlp_pending, fc_credit_ok, dllp_pending} = '0;
        {port_in_d3, pm_turn_off_acked, tlp_seen, tlp_vendor_msg, rx_l0s} = '0;
        rate_5g = 3'h7;
        lt = {LT_DETECT, LT_DETECT, LT_L0};
        repeat (10) @(posedge clk);
        sq.push_back({3'h2, SCAP_RST});
        rstn <= 1'b1;
        lt[1] <= LT_L0;
        chk_pin(port_link_up_ind_n, 16'h0007);
        rd(REG_STATUS, 32'h0000_0003);
        rd(8'h40, 32'h0000_0000);
        @(posedge clk);
        d = rnd();
        spl_rx_valid <= 1'b1;
        {spl_rx_byte1, spl_rx_byte0} <= d[15:0];
        @(posedge clk);
        spl_rx_valid <= 1'b0;
        rd(REG_DEVCAP, {22'h0, d[9:0]});
        d = rnd();
        sq.push_back({3'h2, d[9:0]});
        wr(REG_SCAP_BASE + 8'h04, d);
        d = rnd();
        wr(REG_SCAP_BASE + 8'h08, d);
        sq.push_back({3'h4, d[9:0]});
        lt[2] <= LT_L0;
        tlp_seen <= 3'h7;
        tlp_vendor_msg <= 3'h4;
        @(posedge clk);
        tlp_seen <= 3'h0;
        repeat (50) @(posedge clk);
        chk_pin(port_link_up_ind_n, 16'h0000);
        chk_pin(port_activity_ind_n, 16'h0004);
        repeat (45) @(posedge clk);
        chk_pin(port_activity_ind_n, 16'h0004);
        repeat (110) @(posedge clk);
        chk_pin(port_activity_ind_n, 16'h0007);
        wr(REG_LCTL, 32'h0000_0001);
        for (int i = 0; i < 5; i++) begin
            {rx_l0s, tlp_pending, fc_credit_ok, dllp_pending} <= pat[i];
            @(posedge clk);
            chk_pin(tx_l0s_enter, exl[i]);
        end
        wr(REG_LCTL2, 32'h0000_0007);
        lt <= {LT_RECOVERY, LT_RECOVERY, LT_RECOVERY};
        repeat (2) @(posedge clk);
        lt <= {LT_L0, LT_L0, LT_L0};
        wr(REG_SERDES, 32'h0000_0001);
        rd(REG_LSTS2, 32'h0000_0606);
        chk_pin({adv_deemph_6db, tx_low_swing, tx_deemph_en, tx_deemph_6db},
            16'h0276);
        rate_5g <= 3'h3;
        @(posedge clk);
        chk_pin(tx_deemph_6db, 16'h0002);
        wr(REG_LCTL, 32'h0000_0003);
        port_in_d3 <= 3'h4;
        rd(REG_STATUS, 32'h0000_0007);
        lt[1] <= LT_L1;
        @(posedge clk);
        l1_nak <= 1'b1;
        @(posedge clk);
        l1_nak <= 1'b0;
        dllp_pending <= 3'h1;
        @(posedge clk);
        dllp_pending <= 3'h0;
        chk_pin(l1_req, 16'h0000);
        repeat (6) @(posedge clk);
        rd(REG_STATUS, 32'h0000_0207);
        pm_turn_off_acked <= 3'h1;
        @(posedge clk);
        pm_turn_off_acked <= 3'h0;
        rd(REG_STATUS, 32'h0001_0207);
        chk_pin({l1_req, l1_active, l23_ready}, 16'h0009);
        repeat (2) @(posedge clk);
        wrap_up();
    end
endmodule : plpc_port_link_power_control_tb
